// *** pkg/temp_sense_consts.svh ***
// Constants for the temperature sense and control pin monitor.
`ifndef TEMP_SENSE_CONSTS_SVH
`define TEMP_SENSE_CONSTS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define TS_CLK_HZ        50000000
`define TS_MS_CYCLES     (`TS_CLK_HZ / 1000)
`define SENSOR_BIAS_OUTPUT_MS       24
`define TS_GLITCH_MS     10
`define TS_PRIO_MON_MS   35
`define TS_STD_MON_MS    235

// ****************************************************************
// End of power transfer reason codes
// ****************************************************************
`define EPT_CHARGE_DONE  8'h01
`define EPT_INT_FAULT    8'h02
`define EPT_OVER_TEMP    8'h03
`define EPT_NONE         8'h00

// ****************************************************************
// Register offsets
// ****************************************************************
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_IRQ_STATUS   8'h08
`define REG_IRQ_MASK     8'h0C
`define REG_POWER_BIAS   8'h10
`define REG_RX_POWER     8'h14
`define REG_EPT_CODE     8'h18

// ****************************************************************
// Field positions, limits and reset values
// ****************************************************************
`define CTRL_ENABLE_BIT  0
`define CTRL_PRIO_BIT    1
`define CTRL_RST         2'h0
`define IRQ_EPT_BIT      0
`define IRQ_FAULT_BIT    1
`define IRQ_DONE_BIT     2
`define IRQ_THERM_BIT    3
`define IRQ_RST          4'h0
`define BIAS_RST         8'h00
`define BIAS_LIMIT_MW    8'hFA
`define POWER_MAX        16'hFFFF

`endif

// *** pkg/temp_sense_pkg.sv ***
// Types shared by the temperature sense and control pin monitor.
package temp_sense_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BIAS,
    ST_MONITOR,
    ST_SHUTDOWN
  } sense_state_t;

endpackage

// *** core/deglitch_filter.sv ***
// Deglitch counter for one synchronised comparator level.
`timescale 1ns/1ps

module deglitch_filter #(
  parameter int COUNT_MS = 10,
  parameter int CNT_W    = 8
) (
  input  wire logic ref_clk_i,
  input  wire logic arst_n_i,
  input  wire logic tick_i,
  input  wire logic clear_i,
  input  wire logic level_i,
  output logic      valid_o
);

  logic [CNT_W-1:0] cnt_q;

  // The level must stay high for a whole run of ticks; any low restarts.
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_q   <= '0;
      valid_o <= 1'b0;
    end
    else if (clear_i || !level_i)
    begin
      cnt_q   <= '0;
      valid_o <= 1'b0;
    end
    else if (tick_i && !valid_o)
    begin
      if (cnt_q == CNT_W'(COUNT_MS - 1))
        valid_o <= 1'b1;
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule

// *** core/temp_sense_ctrl.sv ***
// Temperature sense and control pin monitor with register port.
//
// Behaviour
// - Compare pin ratio against hot and cold thresholds.
// - Bias window drives sensor bias for 24 ms.
// - Deglitch each temperature comparator for 10 ms.
// - After window, bias output goes high impedance.
// - Monitor pin against 100 mV, 35/235 ms.
// - Pin above 100 mV unbiased sets host flag.
// - Pin grounded by host: shut down, fault.
// - Pin pulled to battery: shut down, done.
// - Die overheat: regulator off, send code 0x02.
// - Received power is output plus losses.
// - Bias power report within 250 mW shortfall.
// - Host flag set: end transfer, code 0x01.
// - Hot, cold or low pin: code 0x03.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "temp_sense_consts.svh"

module temp_sense_ctrl #(
  parameter int TICK_CYCLES = `TS_MS_CYCLES,
  parameter int BIAS_MS     = `SENSOR_BIAS_OUTPUT_MS,
  parameter int GLITCH_MS   = `TS_GLITCH_MS,
  parameter int PRIO_MS     = `TS_PRIO_MON_MS,
  parameter int STD_MS      = `TS_STD_MON_MS,
  parameter int MS_W        = 8,
  parameter int PWR_W       = 16
) (
  input  wire logic             ref_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [7:0]       addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [31:0]      rdata_o,
  input  wire logic             hot_cmp_i,
  input  wire logic             cold_cmp_i,
  input  wire logic             pin_low_cmp_i,
  input  wire logic             ext_drive_cmp_i,
  input  wire logic             die_hot_i,
  input  wire logic [PWR_W-1:0] out_power_i,
  input  wire logic [PWR_W-1:0] coil_loss_i,
  input  wire logic [PWR_W-1:0] shield_loss_i,
  input  wire logic [PWR_W-1:0] rect_loss_i,
  output logic                  sense_bias_window_o,
  output logic                  sensor_bias_o,
  output logic                  sensor_bias_oe_o,
  output logic                  regulator_en_o,
  output logic                  host_ctrl_o,
  output logic                  fault_o,
  output logic                  charge_done_o,
  output logic                  ept_req_o,
  output logic      [7:0]       ept_code_o,
  output logic      [PWR_W-1:0] rx_power_o,
  output logic                  irq_o
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  temp_sense_pkg::sense_state_t state_q;
  temp_sense_pkg::sense_state_t state_d;
  logic [MS_W-1:0]   ms_cnt_q;
  logic [MS_W-1:0]   ms_cnt_d;
  logic [TICK_W-1:0] tick_cnt_q;
  logic              tick_q;
  logic [1:0]        ctrl_q;
  logic [3:0]        irq_stat_q;
  logic [3:0]        irq_mask_q;
  logic [7:0]        bias_q;
  logic [4:0]        sync1_q;
  logic [4:0]        sync2_q;
  logic [4:0]        sync3_q;
  logic [4:0]        lvl_q;
  logic              hot_ok;
  logic              cold_ok;
  logic              low_ok;
  logic              trip_d;
  logic [7:0]        code_d;
  logic [3:0]        events;
  logic              win_clear;
  logic [PWR_W+2:0]  pwr_sum;
  logic [7:0]        bias_wr;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // A change is accepted only once the second and third stages agree.
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      lvl_q   <= '0;
    end
    else
    begin
      sync1_q <= {die_hot_i, ext_drive_cmp_i, pin_low_cmp_i,
                  cold_cmp_i, hot_cmp_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      lvl_q   <= (sync2_q & sync3_q) | (lvl_q & (sync2_q | sync3_q));
    end
  end

  // ****************************************************************
  // Millisecond tick
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end
    else if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1))
    begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q     <= 1'b0;
    end
  end

  // ****************************************************************
  // Comparator deglitch
  // ****************************************************************
  // Filters restart at every window so a stale count never carries over.
  assign win_clear = (state_q != temp_sense_pkg::ST_BIAS);

  deglitch_filter #(.COUNT_MS(GLITCH_MS), .CNT_W(MS_W)) u_hot (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .tick_i    (tick_q),
    .clear_i   (win_clear),
    .level_i   (lvl_q[0]),
    .valid_o   (hot_ok)
  );

  deglitch_filter #(.COUNT_MS(GLITCH_MS), .CNT_W(MS_W)) u_cold (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .tick_i    (tick_q),
    .clear_i   (win_clear),
    .level_i   (lvl_q[1]),
    .valid_o   (cold_ok)
  );

  deglitch_filter #(.COUNT_MS(GLITCH_MS), .CNT_W(MS_W)) u_low (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .tick_i    (tick_q),
    .clear_i   (win_clear),
    .level_i   (lvl_q[2]),
    .valid_o   (low_ok)
  );

  // ****************************************************************
  // Measurement sequencer
  // ****************************************************************
  // Thermal shutdown outranks the pin, and the pin outranks the timers.
  always_comb
  begin
    state_d  = state_q;
    ms_cnt_d = ms_cnt_q;
    trip_d   = 1'b0;
    code_d   = `EPT_NONE;
    case (state_q)
      temp_sense_pkg::ST_IDLE:
      begin
        ms_cnt_d = '0;
        if (ctrl_q[`CTRL_ENABLE_BIT])
          state_d = temp_sense_pkg::ST_BIAS;
      end
      temp_sense_pkg::ST_BIAS:
      begin
        if (hot_ok || cold_ok || low_ok)
        begin
          state_d = temp_sense_pkg::ST_SHUTDOWN;
          trip_d  = 1'b1;
          code_d  = `EPT_OVER_TEMP;
        end
        else if (tick_q && ms_cnt_q == MS_W'(BIAS_MS - 1))
        begin
          state_d  = temp_sense_pkg::ST_MONITOR;
          ms_cnt_d = '0;
        end
        else if (tick_q)
          ms_cnt_d = ms_cnt_q + 1'b1;
      end
      temp_sense_pkg::ST_MONITOR:
      begin
        if (lvl_q[3])
        begin
          state_d = temp_sense_pkg::ST_SHUTDOWN;
          trip_d  = 1'b1;
          code_d  = `EPT_CHARGE_DONE;
        end
        else if (tick_q && ms_cnt_q == (ctrl_q[`CTRL_PRIO_BIT] ?
                 MS_W'(PRIO_MS - 1) : MS_W'(STD_MS - 1)))
        begin
          state_d  = temp_sense_pkg::ST_BIAS;
          ms_cnt_d = '0;
        end
        else if (tick_q)
          ms_cnt_d = ms_cnt_q + 1'b1;
      end
      temp_sense_pkg::ST_SHUTDOWN:
      begin
        ms_cnt_d = '0;
      end
      default:
      begin
        state_d = temp_sense_pkg::ST_IDLE;
      end
    endcase
    if (lvl_q[4] && state_q != temp_sense_pkg::ST_SHUTDOWN &&
        state_q != temp_sense_pkg::ST_IDLE)
    begin
      state_d = temp_sense_pkg::ST_SHUTDOWN;
      trip_d  = 1'b1;
      code_d  = `EPT_INT_FAULT;
    end
    if (!ctrl_q[`CTRL_ENABLE_BIT])
    begin
      state_d = temp_sense_pkg::ST_IDLE;
      trip_d  = 1'b0;
      code_d  = `EPT_NONE;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q  <= temp_sense_pkg::ST_IDLE;
      ms_cnt_q <= '0;
    end
    else
    begin
      state_q  <= state_d;
      ms_cnt_q <= ms_cnt_d;
    end
  end

  // ****************************************************************
  // Pin drive and power stage control
  // ****************************************************************
  // Outside the window the pin is released so a host can drive it.
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sense_bias_window_o <= 1'b0;
      sensor_bias_o       <= 1'b0;
      sensor_bias_oe_o    <= 1'b0;
      regulator_en_o      <= 1'b0;
    end
    else
    begin
      sense_bias_window_o <= (state_d == temp_sense_pkg::ST_BIAS);
      sensor_bias_o       <= (state_d == temp_sense_pkg::ST_BIAS);
      sensor_bias_oe_o    <= (state_d == temp_sense_pkg::ST_BIAS);
      regulator_en_o      <= (state_d == temp_sense_pkg::ST_BIAS) ||
                             (state_d == temp_sense_pkg::ST_MONITOR);
    end
  end

  // ****************************************************************
  // Shutdown reporting
  // ****************************************************************
  // Flags hold until software drops the enable bit.
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      host_ctrl_o   <= 1'b0;
      fault_o       <= 1'b0;
      charge_done_o <= 1'b0;
      ept_req_o     <= 1'b0;
      ept_code_o    <= `EPT_NONE;
    end
    else
    begin
      ept_req_o <= trip_d;
      if (trip_d)
        ept_code_o <= code_d;
      if (state_d == temp_sense_pkg::ST_IDLE)
      begin
        host_ctrl_o   <= 1'b0;
        fault_o       <= 1'b0;
        charge_done_o <= 1'b0;
      end
      else if (trip_d)
      begin
        host_ctrl_o   <= (code_d == `EPT_CHARGE_DONE);
        charge_done_o <= (code_d == `EPT_CHARGE_DONE);
        fault_o       <= (code_d != `EPT_CHARGE_DONE);
      end
    end
  end

  // ****************************************************************
  // Received power estimate
  // ****************************************************************
  // The bias register lifts the estimate toward the transmitted power.
  assign pwr_sum = (PWR_W+3)'(out_power_i) + (PWR_W+3)'(coil_loss_i) +
                   (PWR_W+3)'(shield_loss_i) + (PWR_W+3)'(rect_loss_i) +
                   (PWR_W+3)'(bias_q);

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rx_power_o <= '0;
    else if (pwr_sum > (PWR_W+3)'(`POWER_MAX))
      rx_power_o <= PWR_W'(`POWER_MAX);
    else
      rx_power_o <= pwr_sum[PWR_W-1:0];
  end

  // ****************************************************************
  // Register port
  // ****************************************************************
  // The whole word is compared so that a large value cannot wrap low.
  assign bias_wr = (wdata_i > {24'h0, `BIAS_LIMIT_MW}) ? `BIAS_LIMIT_MW :
                   wdata_i[7:0];

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_q     <= `CTRL_RST;
      irq_mask_q <= `IRQ_RST;
      bias_q     <= `BIAS_RST;
    end
    else if (wr_i)
    begin
      if (addr_i == `REG_CTRL)
        ctrl_q <= wdata_i[1:0];
      if (addr_i == `REG_IRQ_MASK)
        irq_mask_q <= wdata_i[3:0];
      if (addr_i == `REG_POWER_BIAS)
        bias_q <= bias_wr;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_o <= '0;
    else if (rd_i)
      case (addr_i)
        `REG_CTRL:       rdata_o <= {30'h0, ctrl_q};
        `REG_STATUS:     rdata_o <= {26'h0, regulator_en_o, lvl_q[4],
                                     charge_done_o, fault_o, host_ctrl_o,
                                     sense_bias_window_o};
        `REG_IRQ_STATUS: rdata_o <= {28'h0, irq_stat_q};
        `REG_IRQ_MASK:   rdata_o <= {28'h0, irq_mask_q};
        `REG_POWER_BIAS: rdata_o <= {24'h0, bias_q};
        `REG_RX_POWER:   rdata_o <= {{(32-PWR_W){1'b0}}, rx_power_o};
        `REG_EPT_CODE:   rdata_o <= {24'h0, ept_code_o};
        default:         rdata_o <= '0;
      endcase
    else
      rdata_o <= '0;
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  always_comb
  begin
    events                 = '0;
    events[`IRQ_EPT_BIT]   = trip_d;
    events[`IRQ_FAULT_BIT] = trip_d && (code_d != `EPT_CHARGE_DONE);
    events[`IRQ_DONE_BIT]  = trip_d && (code_d == `EPT_CHARGE_DONE);
    events[`IRQ_THERM_BIT] = trip_d && (code_d == `EPT_INT_FAULT);
  end

  // A new event in the clearing cycle survives the write of one.
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_stat_q <= `IRQ_RST;
      irq_o      <= 1'b0;
    end
    else
    begin
      if (wr_i && addr_i == `REG_IRQ_STATUS)
        irq_stat_q <= (irq_stat_q & ~wdata_i[3:0]) | events;
      else
        irq_stat_q <= irq_stat_q | events;
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule

// *** bench/sense_pin_model.sv ***
// Thermistor divider and host three-state driver on the sense pin.
`timescale 1ns/1ps

module sense_pin_model (
  input  wire logic       bias_oe_i,
  input  wire logic [1:0] temp_mode_i,
  input  wire logic [1:0] host_mode_i,
  output logic            hot_o,
  output logic            cold_o,
  output logic            low_o,
  output logic            ext_o
);
  // Temperature modes: 0 normal, 1 hot, 2 cold. Host modes: 0 released,
  // 1 pulled to ground, 2 pulled to the battery.
  logic grounded;
  logic pulled_up;

  // A released driver leaves only the divider, which reads 0 V unbiased.
  assign pulled_up = (host_mode_i == 2'h2);
  assign grounded  = bias_oe_i && (host_mode_i == 2'h1);
  // Ratio thresholds only mean something while the divider is biased.
  assign hot_o  = bias_oe_i && (temp_mode_i == 2'h1 || grounded);
  assign cold_o = bias_oe_i && (temp_mode_i == 2'h2 || pulled_up);
  assign low_o  = grounded;
  assign ext_o  = !bias_oe_i && pulled_up;
endmodule

// *** bench/temp_sense_chk.sv ***
// Assertion checker for the temperature sense and control pin monitor.
`timescale 1ns/1ps
`include "temp_sense_consts.svh"

module temp_sense_chk #(
  parameter int TICK_CYCLES = 4,
  parameter int BIAS_MS     = 24,
  parameter int GLITCH_MS   = 10,
  parameter int PRIO_MS     = 35,
  parameter int STD_MS      = 235
) (
  input wire logic        ref_clk_i,
  input wire logic        arst_n_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        sense_bias_window_o,
  input wire logic        sensor_bias_o,
  input wire logic        sensor_bias_oe_o,
  input wire logic        regulator_en_o,
  input wire logic        host_ctrl_o,
  input wire logic        fault_o,
  input wire logic        charge_done_o,
  input wire logic        ept_req_o,
  input wire logic [7:0]  ept_code_o
);
  // ********
  // Interval counters
  // ********
  // Windows are far too long for a repetition count, so they are counted.
  logic [15:0] hi_q;
  logic [15:0] lo_q;

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      hi_q <= 16'h0000;
      lo_q <= 16'h0000;
    end
    else
    begin
      hi_q <= sense_bias_window_o ? hi_q + 16'h0001 : 16'h0000;
      lo_q <= (regulator_en_o && !sense_bias_window_o) ?
              lo_q + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // ********
  // Properties
  // ********
  AST_BIAS_DRIVE: assert property (
    sense_bias_window_o |-> sensor_bias_oe_o && sensor_bias_o)
    else $error("bias not driven in window");
  AST_BIAS_RELEASE: assert property (
    !sense_bias_window_o |-> !sensor_bias_oe_o)
    else $error("bias driven outside window");
  AST_WINDOW_MAX: assert property (
    hi_q <= BIAS_MS * TICK_CYCLES + 2)
    else $error("bias window too long");
  AST_WINDOW_MIN: assert property (
    $fell(sense_bias_window_o) && regulator_en_o |->
    $past(hi_q) >= (BIAS_MS - 1) * TICK_CYCLES - 1)
    else $error("bias window too short");
  AST_MONITOR_MAX: assert property (
    lo_q <= STD_MS * TICK_CYCLES + 2)
    else $error("monitor interval too long");
  AST_MONITOR_MIN: assert property (
    $rose(sense_bias_window_o) && $past(regulator_en_o) |->
    $past(lo_q) >= (PRIO_MS - 1) * TICK_CYCLES - 1)
    else $error("monitor interval too short");
  AST_EPT_PULSE: assert property (
    ept_req_o |=> !ept_req_o)
    else $error("end request longer than one cycle");
  AST_DONE_FLAGS: assert property (
    ept_req_o && ept_code_o == `EPT_CHARGE_DONE |->
    charge_done_o && host_ctrl_o && !fault_o && !regulator_en_o)
    else $error("charge complete flags wrong");
  AST_FAULT_FLAGS: assert property (
    ept_req_o && ept_code_o != `EPT_CHARGE_DONE |->
    fault_o && !charge_done_o && !regulator_en_o &&
    (ept_code_o inside {`EPT_INT_FAULT, `EPT_OVER_TEMP}))
    else $error("fault flags or code wrong");
  AST_HOST_UNBIASED: assert property (
    $rose(host_ctrl_o) |-> !$past(sense_bias_window_o))
    else $error("host flag set while biased");
  AST_DEGLITCH: assert property (
    ept_req_o && ept_code_o == `EPT_OVER_TEMP |->
    $past(hi_q) >= (GLITCH_MS - 1) * TICK_CYCLES - 2)
    else $error("comparator accepted before deglitch");
  AST_READ_IDLE: assert property (
    !$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data outside read cycle");

  cover property (ept_req_o && ept_code_o == `EPT_OVER_TEMP);
  cover property (ept_req_o && ept_code_o == `EPT_INT_FAULT);
  cover property (ept_req_o && ept_code_o == `EPT_CHARGE_DONE);
  cover property ($fell(sense_bias_window_o) && regulator_en_o);
endmodule

// *** bench/testbench.sv ***
// Self-checking testbench for the temperature sense and control pin monitor.
`timescale 1ns/1ps
`include "temp_sense_consts.svh"

module testbench;
  logic        ref_clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        die_hot_i = 1'b0;
  logic [15:0] out_power_i = 16'h0000;
  logic [15:0] coil_loss_i = 16'h0000;
  logic [15:0] shield_loss_i = 16'h0000;
  logic [15:0] rect_loss_i = 16'h0000;
  logic [1:0]  temp_mode = 2'h0;
  logic [1:0]  host_mode = 2'h0;
  logic [31:0] rdata_o;
  logic [7:0]  ept_code_o;
  logic [15:0] rx_power_o;
  logic        hot_cmp_i, cold_cmp_i, pin_low_cmp_i, ext_drive_cmp_i;
  logic        sense_bias_window_o, sensor_bias_o, sensor_bias_oe_o;
  logic        regulator_en_o, host_ctrl_o, fault_o, charge_done_o;
  logic        ept_req_o, irq_o;
  logic [7:0]  regs [8] = '{`REG_CTRL, `REG_STATUS, `REG_IRQ_STATUS,
    `REG_IRQ_MASK, `REG_POWER_BIAS, `REG_RX_POWER, `REG_EPT_CODE, 8'h1C};
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          rises = 0;

  always #10 ref_clk_i = ~ref_clk_i;
  always @(posedge sense_bias_window_o) rises++;

  // Counts are shortened so that every interval fits a short run.
  temp_sense_ctrl #(.TICK_CYCLES(4), .BIAS_MS(6), .GLITCH_MS(3),
    .PRIO_MS(4), .STD_MS(8)) dut_u (
    .ref_clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .hot_cmp_i, .cold_cmp_i, .pin_low_cmp_i, .ext_drive_cmp_i, .die_hot_i,
    .out_power_i, .coil_loss_i, .shield_loss_i, .rect_loss_i,
    .sense_bias_window_o, .sensor_bias_o, .sensor_bias_oe_o,
    .regulator_en_o, .host_ctrl_o, .fault_o, .charge_done_o, .ept_req_o,
    .ept_code_o, .rx_power_o, .irq_o);

  sense_pin_model pin_u (.bias_oe_i(sensor_bias_oe_o), .temp_mode_i(temp_mode),
    .host_mode_i(host_mode), .hot_o(hot_cmp_i), .cold_o(cold_cmp_i),
    .low_o(pin_low_cmp_i), .ext_o(ext_drive_cmp_i));

  // ********
  // Tasks
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(rdata_o, exp);
    // Return just after a rising edge so callers drive inputs there.
    @(posedge ref_clk_i);
  endtask

  // A host pull-up or a die fault is applied only once the bias is off, as a host
  // pulling up during the window would read as cold instead.
  task automatic shut(input logic [1:0] tm, input logic [1:0] hm,
                      input logic dh, input logic [7:0] c,
                      input logic [3:0] st);
    int n;
    wr(`REG_CTRL, 32'h0);
    wr(`REG_IRQ_STATUS, 32'hF);
    temp_mode <= tm;
    wr(`REG_CTRL, 32'h1);
    if (hm == 2'h2 || dh)
      @(negedge sense_bias_window_o);
    host_mode <= hm;
    die_hot_i <= dh;
    for (n = 0; n < 400 && ept_req_o !== 1'b1; n++)
      @(negedge ref_clk_i);
    chk(ept_req_o, 1'b1);
    chk({24'h0, ept_code_o}, {24'h0, c});
    chk(regulator_en_o, 1'b0);
    rd(`REG_STATUS, {26'h0, 1'b0, dh, c == `EPT_CHARGE_DONE,
       c != `EPT_CHARGE_DONE, c == `EPT_CHARGE_DONE, 1'b0});
    rd(`REG_IRQ_STATUS, {28'h0, st});
    rd(`REG_EPT_CODE, {24'h0, c});
    temp_mode <= 2'h0;
    host_mode <= 2'h0;
    die_hot_i <= 1'b0;
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A hang anywhere is cut off well beyond the expected run length.
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      miscompares++;
      final_report();
    end
  end

  // ********
  // Tests
  // ********
  initial
  begin
    repeat (20) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    foreach (regs[i])
      rd(regs[i], 32'h0);
    out_power_i   <= 16'h03E8;
    coil_loss_i   <= 16'h0032;
    shield_loss_i <= 16'h0014;
    rect_loss_i   <= 16'h001E;
    wr(`REG_POWER_BIAS, 32'h12C);
    rd(`REG_POWER_BIAS, 32'hFA);
    wr(`REG_RX_POWER, 32'h0);
    rd(`REG_RX_POWER, 32'h546);
    wr(`REG_POWER_BIAS, 32'h10);
    out_power_i <= 16'hFFC0;
    rd(`REG_POWER_BIAS, 32'h10);
    chk(rx_power_o, 16'hFFFF);
    $display("test registers done");

    shut(2'h1, 2'h0, 1'b0, `EPT_OVER_TEMP, 4'h3);
    chk(irq_o, 1'b0);
    wr(`REG_IRQ_MASK, 32'hF);
    repeat (2) @(negedge ref_clk_i);
    chk(irq_o, 1'b1);
    rd(`REG_IRQ_MASK, 32'hF);
    wr(`REG_IRQ_STATUS, 32'hF);
    repeat (2) @(negedge ref_clk_i);
    chk(irq_o, 1'b0);
    shut(2'h2, 2'h0, 1'b0, `EPT_OVER_TEMP, 4'h3);
    shut(2'h0, 2'h1, 1'b0, `EPT_OVER_TEMP, 4'h3);
    shut(2'h0, 2'h2, 1'b0, `EPT_CHARGE_DONE, 4'h5);
    shut(2'h0, 2'h0, 1'b1, `EPT_INT_FAULT, 4'hB);
    $display("test shutdowns done");

    wr(`REG_CTRL, 32'h0);
    rises = 0;
    wr(`REG_CTRL, 32'h3);
    repeat (200) @(negedge ref_clk_i);
    chk(rises >= 5, 1'b1);
    chk(regulator_en_o, 1'b1);
    wr(`REG_CTRL, 32'h0);
    rises = 0;
    wr(`REG_CTRL, 32'h1);
    repeat (200) @(negedge ref_clk_i);
    chk(rises <= 4 && rises >= 3, 1'b1);
    chk(fault_o, 1'b0);
    $display("test cycling done");
    final_report();
  end
endmodule

bind temp_sense_ctrl temp_sense_chk #(.TICK_CYCLES(TICK_CYCLES),
  .BIAS_MS(BIAS_MS), .GLITCH_MS(GLITCH_MS), .PRIO_MS(PRIO_MS),
  .STD_MS(STD_MS)) chk_u (.ref_clk_i, .arst_n_i, .rd_i, .rdata_o,
  .sense_bias_window_o, .sensor_bias_o, .sensor_bias_oe_o, .regulator_en_o,
  .host_ctrl_o, .fault_o, .charge_done_o, .ept_req_o, .ept_code_o);
